/* obdscn_pkg.sv */
// obdscn_pkg: constants for the can rate and identifier scan sequencer
// assumes a 125 MHz clock; used by obdscn_top and obdscn_resp
package obdscn_pkg;
    localparam int CLK_MHZ = 125;
    // sender frame timeout, in ms
    localparam int SENDER_TIMEOUT_MS = 25;
    localparam int SENDER_TIMEOUT_CYC = SENDER_TIMEOUT_MS * 1000 * CLK_MHZ;
    // disconnect targets, in us (longest times, rounded down)
    localparam int DISC_TARGET_US = 12;
    localparam int DISC_LIMIT_US = 100;
    localparam int DISC_TARGET_CYC = DISC_TARGET_US * CLK_MHZ;
    localparam int DISC_LIMIT_CYC = DISC_LIMIT_US * CLK_MHZ;
    // request content
    localparam logic [7:0] REQ_SERVICE = 8'h01;
    localparam logic [7:0] REQ_PARAM = 8'h00;
    localparam logic [7:0] RESP_POS = 8'h41;
    localparam logic [7:0] RESP_NEG0 = 8'h7F;
    localparam logic [7:0] RESP_NEG1 = 8'h01;
    // identifiers
    localparam logic [28:0] FUNC_ID_STD = 29'h000007DF;
    localparam logic [28:0] FUNC_ID_EXT = 29'h18DB33F1;
    localparam logic [28:0] RESP_ID_STD = 29'h000007E8;
    localparam logic [28:0] RESP_ID_STD_MASK = 29'h1FFFFFF8;
    localparam logic [28:0] RESP_ID_EXT = 29'h18DAF100;
    localparam logic [28:0] RESP_ID_EXT_MASK = 29'h1FFFFF00;
    // error codes from the can controller
    localparam logic [2:0] ERR_NONE = 3'h0;
    localparam logic [2:0] ERR_ACK = 3'h1;
    // tag value for a source with no entry in the tag table
    localparam logic [7:0] TAG_UNDEF = 8'hFF;
    localparam int MAX_UNITS = 8;
    localparam logic [15:0] RATE_NONE = 16'h0000;
    typedef enum logic [1:0] {
        OBDSCN_RES_NONE,
        OBDSCN_RES_STD,
        OBDSCN_RES_EXT,
        OBDSCN_RES_FAIL
    } obdscn_result_t;
endpackage : obdscn_pkg

/* obdscn_resp.sv */
// obdscn_resp: classifies replies and keeps the responder address list
// assumes reply fields arrive from the can controller on the same clock
`timescale 1ns/1ps
module obdscn_resp #(
    parameter int UNITS = obdscn_pkg::MAX_UNITS
) (
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // control
    input wire logic clear,
    input wire logic ext_mode,
    input wire logic listen,
    // received frame
    input wire logic rx_valid,
    input wire logic [28:0] rx_id,
    input wire logic [7:0] rx_byte0,
    input wire logic [7:0] rx_byte1,
    // tag table
    input wire logic tag_wr,
    input wire logic [2:0] tag_idx,
    input wire logic [7:0] tag_addr,
    input wire logic [7:0] tag_val,
    // results
    output logic pos_seen,
    output logic pos_pulse,
    output logic neg_pulse,
    output logic [7:0] src_addr,
    output logic [7:0] tag_out,
    output logic [UNITS*8-1:0] responders,
    output logic [UNITS-1:0] responder_valid
);
    logic [7:0] tab_addr_q [UNITS];
    logic [7:0] tab_tag_q [UNITS];
    logic [UNITS-1:0] tab_used_q;
    logic [UNITS-1:0] hit;
    logic [UNITS-1:0] known;
    logic [UNITS-1:0] first_free;
    logic [7:0] tag_pick;
    logic [7:0] src;
    logic id_ok;
    logic is_pos;
    logic is_neg;
    logic pos_seen_q;

    assign id_ok = ext_mode ?
        ((rx_id & obdscn_pkg::RESP_ID_EXT_MASK) == obdscn_pkg::RESP_ID_EXT) :
        ((rx_id & obdscn_pkg::RESP_ID_STD_MASK) == obdscn_pkg::RESP_ID_STD);
    // std source is the response id low bits, ext source the low byte
    assign src = ext_mode ? rx_id[7:0] : {5'h00, rx_id[2:0]};
    assign is_pos = listen && rx_valid && id_ok &&
        (rx_byte0 == obdscn_pkg::RESP_POS);
    assign is_neg = listen && rx_valid && id_ok &&
        (rx_byte0 == obdscn_pkg::RESP_NEG0) &&
        (rx_byte1 == obdscn_pkg::RESP_NEG1);

    genvar g;
    generate
        for (g = 0; g < UNITS; g++) begin : g_unit
            assign hit[g] = tab_used_q[g] && (tab_addr_q[g] == src);
            assign known[g] = responder_valid[g] &&
                (responders[g*8 +: 8] == src);
            assign first_free[g] = !responder_valid[g] &&
                ((g == 0) ? 1'b1 : &responder_valid[(g == 0 ? 0 : g-1):0]);
            always_ff @(posedge clock) begin
                if (!resetn) begin
                    tab_used_q[g] <= 1'b0;
                    tab_addr_q[g] <= 8'h00;
                    tab_tag_q[g] <= 8'h00;
                    responder_valid[g] <= 1'b0;
                    responders[g*8 +: 8] <= 8'h00;
                end else begin
                    if (tag_wr && tag_idx == 3'(g)) begin
                        tab_used_q[g] <= 1'b1;
                        tab_addr_q[g] <= tag_addr;
                        tab_tag_q[g] <= tag_val;
                    end
                    if (clear) begin
                        responder_valid[g] <= 1'b0;
                    end else if ((is_pos || is_neg) && first_free[g] &&
                        !(|known)) begin
                        responder_valid[g] <= 1'b1;
                        responders[g*8 +: 8] <= src;
                    end
                end
            end
        end
    endgenerate

    always_comb begin
        tag_pick = obdscn_pkg::TAG_UNDEF;
        for (int i = 0; i < UNITS; i++) begin
            if (hit[i]) begin
                tag_pick = tab_tag_q[i];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            pos_seen_q <= 1'b0;
            pos_pulse <= 1'b0;
            neg_pulse <= 1'b0;
            src_addr <= 8'h00;
            tag_out <= 8'h00;
        end else begin
            pos_seen_q <= clear ? 1'b0 : (pos_seen_q | is_pos);
            pos_pulse <= is_pos;
            neg_pulse <= is_neg;
            if (is_pos || is_neg) begin
                src_addr <= src;
                tag_out <= tag_pick;
            end
        end
    end
    assign pos_seen = pos_seen_q;
endmodule : obdscn_resp

/* obdscn_top.sv */
// obdscn_top: bit rate and identifier size scan for the diagnostic can bus
// assumes a can controller on the same clock that reports errors at once
`timescale 1ns/1ps
module obdscn_top #(
    parameter int RATES = 4,
    parameter int TIMEOUT_CYC = obdscn_pkg::SENDER_TIMEOUT_CYC,
    parameter int UNITS = obdscn_pkg::MAX_UNITS
) (
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // configuration
    input wire logic start,
    input wire logic [RATES*16-1:0] candidate_rate_list,
    input wire logic [2:0] rate_count,
    input wire logic [15:0] active_bit_rate_setting,
    input wire logic transmit_confirm_enable,
    input wire logic header_info_enable,
    input wire logic [23:0] resp_window,
    // tag table
    input wire logic tag_wr,
    input wire logic [2:0] tag_idx,
    input wire logic [7:0] tag_addr,
    input wire logic [7:0] tag_val,
    // can controller
    output logic [15:0] can_rate,
    output logic can_connect,
    output logic can_tx_req,
    output logic can_tx_abort,
    output logic can_ext_id,
    output logic [28:0] can_tx_id,
    output logic [15:0] can_tx_data,
    input wire logic can_tx_ok,
    input wire logic [2:0] can_err,
    input wire logic rx_valid,
    input wire logic [28:0] rx_id,
    input wire logic [7:0] rx_byte0,
    input wire logic [7:0] rx_byte1,
    // results
    output logic busy,
    output logic transmit_done_flag,
    output logic tx_failed,
    output logic [1:0] result,
    output logic [15:0] detected_rate,
    output logic resp_pos,
    output logic resp_neg,
    output logic [7:0] resp_src,
    output logic [7:0] response_tag,
    output logic [UNITS*8-1:0] responders,
    output logic [UNITS-1:0] responder_valid
);
    typedef enum logic [2:0] {
        S_IDLE, S_SETUP, S_SEND, S_WAIT_TX, S_LISTEN, S_DONE
    } obdscn_state_t;

    obdscn_state_t state_q, state_d;
    logic [2:0] idx_q;
    logic ext_q;
    logic [31:0] tmo_q;
    logic [23:0] win_q;
    logic pos_seen;
    logic pos_pulse;
    logic neg_pulse;
    logic [7:0] src_w;
    logic [7:0] tag_w;
    logic [15:0] cand_w;
    logic [15:0] rate_sel;
    logic err_any;
    logic err_ack;
    logic more_rates;
    logic tmo_hit;
    logic clear_w;

    assign cand_w = candidate_rate_list[idx_q*16 +: 16];
    // empty list falls back to the active setting
    assign rate_sel = (rate_count == 3'h0) ?
        active_bit_rate_setting : cand_w;
    assign err_any = can_err != obdscn_pkg::ERR_NONE;
    assign err_ack = can_err == obdscn_pkg::ERR_ACK;
    // a single entry list runs once, i.e. without trying a further rate
    assign more_rates = !ext_q &&
        (32'(idx_q) + 1 < 32'(rate_count)) &&
        (32'(idx_q) + 1 < RATES);
    assign tmo_hit = tmo_q >= 32'(TIMEOUT_CYC);
    assign clear_w = (state_q == S_IDLE) && start;

    always_comb begin
        state_d = state_q;
        case (state_q)
            S_IDLE: if (start) state_d = S_SETUP;
            S_SETUP: begin
                if (ext_q && detected_rate == obdscn_pkg::RATE_NONE) begin
                    state_d = S_DONE;
                end else begin
                    state_d = S_SEND;
                end
            end
            S_SEND: state_d = S_WAIT_TX;
            S_WAIT_TX: begin
                if (can_tx_ok) begin
                    state_d = S_LISTEN;
                end else if (err_ack && !tmo_hit) begin
                    state_d = S_SEND;
                end else if (err_any) begin
                    state_d = more_rates ? S_SETUP : S_DONE;
                end
            end
            S_LISTEN: begin
                if (win_q >= resp_window) begin
                    state_d = (pos_seen || ext_q) ? S_DONE : S_SETUP;
                end
            end
            S_DONE: state_d = S_IDLE;
            default: state_d = S_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            state_q <= S_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // rate index, identifier size and timers
    always_ff @(posedge clock) begin
        if (!resetn) begin
            idx_q <= 3'h0;
            ext_q <= 1'b0;
            tmo_q <= 32'h00000000;
            win_q <= 24'h000000;
        end else begin
            if (clear_w) begin
                idx_q <= 3'h0;
                ext_q <= 1'b0;
            end else if (state_q == S_WAIT_TX && err_any &&
                !(err_ack && !tmo_hit) && more_rates) begin
                idx_q <= idx_q + 3'h1;
            end else if (state_q == S_LISTEN && state_d == S_SETUP) begin
                ext_q <= 1'b1;
            end
            if (state_q == S_SETUP) begin
                tmo_q <= 32'h00000000;
            end else if (!tmo_hit) begin
                tmo_q <= tmo_q + 32'h00000001;
            end
            win_q <= (state_q == S_LISTEN) ? win_q + 24'h000001 :
                24'h000000;
        end
    end

    // controller drive; an error drops the link in the same edge, except an ack error before the timeout
    always_ff @(posedge clock) begin
        if (!resetn) begin
            can_rate <= obdscn_pkg::RATE_NONE;
            can_connect <= 1'b0;
            can_tx_req <= 1'b0;
            can_tx_abort <= 1'b0;
            can_ext_id <= 1'b0;
            can_tx_id <= obdscn_pkg::FUNC_ID_STD;
            can_tx_data <= 16'h0000;
        end else begin
            if (state_q == S_SETUP && !ext_q) begin
                can_rate <= rate_sel;
            end
            if (state_q == S_SETUP) begin
                can_ext_id <= ext_q;
                can_tx_id <= ext_q ? obdscn_pkg::FUNC_ID_EXT :
                    obdscn_pkg::FUNC_ID_STD;
                can_tx_data <= {obdscn_pkg::REQ_SERVICE,
                    obdscn_pkg::REQ_PARAM};
            end
            can_tx_req <= state_q == S_SEND;
            if (state_d == S_SEND || state_d == S_WAIT_TX ||
                state_d == S_LISTEN) begin
                can_connect <= 1'b1;
            end else begin
                can_connect <= 1'b0;
            end
            can_tx_abort <= state_q == S_WAIT_TX && err_any &&
                !(err_ack && !tmo_hit);
        end
    end

    // status
    always_ff @(posedge clock) begin
        if (!resetn) begin
            busy <= 1'b0;
            transmit_done_flag <= 1'b0;
            tx_failed <= 1'b0;
            result <= obdscn_pkg::OBDSCN_RES_NONE;
            detected_rate <= obdscn_pkg::RATE_NONE;
        end else begin
            busy <= state_d != S_IDLE;
            if (clear_w) begin
                detected_rate <= obdscn_pkg::RATE_NONE;
                transmit_done_flag <= 1'b0;
                tx_failed <= 1'b0;
                result <= obdscn_pkg::OBDSCN_RES_NONE;
            end
            if (state_q == S_WAIT_TX && can_tx_ok && !ext_q) begin
                transmit_done_flag <= transmit_confirm_enable;
                detected_rate <= can_rate;
            end
            if (state_q == S_WAIT_TX && state_d == S_DONE) begin
                tx_failed <= 1'b1;
                result <= obdscn_pkg::OBDSCN_RES_FAIL;
            end
            if (state_q == S_SETUP && state_d == S_DONE) begin
                tx_failed <= 1'b1;
                result <= obdscn_pkg::OBDSCN_RES_FAIL;
            end
            if (state_q == S_LISTEN && state_d == S_DONE) begin
                result <= !pos_seen ? obdscn_pkg::OBDSCN_RES_FAIL :
                    ext_q ? obdscn_pkg::OBDSCN_RES_EXT :
                    obdscn_pkg::OBDSCN_RES_STD;
            end
        end
    end

    // responses, header bytes only when asked for
    always_ff @(posedge clock) begin
        if (!resetn) begin
            resp_pos <= 1'b0;
            resp_neg <= 1'b0;
            resp_src <= 8'h00;
            response_tag <= 8'h00;
        end else begin
            resp_pos <= pos_pulse;
            resp_neg <= neg_pulse;
            resp_src <= header_info_enable ? src_w : 8'h00;
            response_tag <= tag_w;
        end
    end

    obdscn_resp #(.UNITS(UNITS)) u_resp (
        .clock(clock),
        .resetn(resetn),
        .clear(clear_w || (state_q == S_LISTEN && state_d == S_SETUP)),
        .ext_mode(ext_q),
        .listen(state_q == S_LISTEN),
        .rx_valid(rx_valid),
        .rx_id(rx_id),
        .rx_byte0(rx_byte0),
        .rx_byte1(rx_byte1),
        .tag_wr(tag_wr),
        .tag_idx(tag_idx),
        .tag_addr(tag_addr),
        .tag_val(tag_val),
        .pos_seen(pos_seen),
        .pos_pulse(pos_pulse),
        .neg_pulse(neg_pulse),
        .src_addr(src_w),
        .tag_out(tag_w),
        .responders(responders),
        .responder_valid(responder_valid)
    );
endmodule : obdscn_top

/* obdscn_props.sv */
// obdscn_props: port assertions for the rate and identifier scan
// assumes a bind onto obdscn_top, one clock, sync active low reset
`timescale 1ns/1ps
module obdscn_props #(
    parameter int RATES = 4,
    parameter int TIMEOUT_CYC = 200,
    parameter int UNITS = 8
) (
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // configuration
    input wire logic start,
    input wire logic transmit_confirm_enable,
    // can controller
    input wire logic [15:0] can_rate,
    input wire logic can_connect,
    input wire logic can_tx_req,
    input wire logic can_tx_abort,
    input wire logic can_ext_id,
    input wire logic [28:0] can_tx_id,
    input wire logic [15:0] can_tx_data,
    input wire logic can_tx_ok,
    input wire logic [2:0] can_err,
    // results
    input wire logic busy,
    input wire logic transmit_done_flag,
    input wire logic [15:0] detected_rate
);
    logic [31:0] conn_cyc_q;
    logic [31:0] conn_cyc_d;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    // cycles since the link was joined
    assign conn_cyc_d = can_connect ? conn_cyc_q + 32'h1 : 32'h0;
    always_ff @(posedge clock) begin
        conn_cyc_q <= resetn ? conn_cyc_d : 32'h0;
    end
    sequence s_go;
        start && !busy;
    endsequence
    sequence s_setup;
        busy [*2] ##1 (busy && can_tx_req);
    endsequence
    sequence s_bad;
        can_connect && can_err != 3'h0 && can_err != 3'h1;
    endsequence
    property p_busy; s_go |=> busy; endproperty
    a_busy: assert property (p_busy) else $error("busy late");
    property p_req; s_go |=> s_setup; endproperty
    a_req: assert property (p_req) else $error("no request");
    property p_data;
        can_tx_req |-> can_connect && can_tx_data == 16'h0100;
    endproperty
    a_data: assert property (p_data) else $error("bad data");
    property p_id;
        can_tx_req |-> can_tx_id == (can_ext_id ? 29'h18DB33F1 : 29'h7DF);
    endproperty
    a_id: assert property (p_id) else $error("bad id");
    property p_disc; s_bad |=> !can_connect && can_tx_abort; endproperty
    a_disc: assert property (p_disc)
        else $error("late drop");
    property p_dead; !can_connect |-> !can_tx_req; endproperty
    a_dead: assert property (p_dead)
        else $error("send offline");
    property p_abort; can_tx_abort |=> !can_tx_abort; endproperty
    a_abort: assert property (p_abort)
        else $error("long abort");
    property p_done;
        can_connect && can_tx_ok && transmit_confirm_enable |=>
            transmit_done_flag && detected_rate == $past(can_rate);
    endproperty
    a_done: assert property (p_done) else $error("no done");
    property p_ack;
        can_connect && can_err == 3'h1 |-> ##[1:8] (can_tx_req || !can_connect);
    endproperty
    a_ack: assert property (p_ack) else $error("no retry");
    property p_late; can_tx_req |-> conn_cyc_q <= TIMEOUT_CYC + 4; endproperty
    a_late: assert property (p_late) else $error("retry late");
    property p_ext;
        can_tx_req && can_ext_id |-> can_rate == detected_rate &&
            detected_rate != 16'h0000;
    endproperty
    a_ext: assert property (p_ext) else $error("ext rate");
endmodule : obdscn_props

bind obdscn_top obdscn_props #(.RATES(RATES), .TIMEOUT_CYC(TIMEOUT_CYC),
    .UNITS(UNITS)) obdscn_props_inst (.clock(clock), .resetn(resetn),
    .start(start), .transmit_confirm_enable(transmit_confirm_enable),
    .can_rate(can_rate), .can_connect(can_connect), .can_tx_req(can_tx_req),
    .can_tx_abort(can_tx_abort), .can_ext_id(can_ext_id),
    .can_tx_id(can_tx_id), .can_tx_data(can_tx_data),
    .can_tx_ok(can_tx_ok), .can_err(can_err), .busy(busy),
    .transmit_done_flag(transmit_done_flag), .detected_rate(detected_rate));

/* obdscn_bus.sv */
// obdscn_bus: vehicle bus and control units behind the can controller
// assumes requests as pulses while the link is joined
`timescale 1ns/1ps
module obdscn_bus (
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // scenario control
    input wire logic [15:0] good_rate,
    input wire logic ack_missing,
    input wire logic [1:0] std_reply,
    input wire logic ext_reply,
    // controller side
    input wire logic [15:0] can_rate,
    input wire logic can_connect,
    input wire logic can_tx_req,
    input wire logic can_ext_id,
    output logic can_tx_ok,
    output logic [2:0] can_err,
    output logic rx_valid,
    output logic [28:0] rx_id,
    output logic [7:0] rx_byte0,
    output logic [7:0] rx_byte1
);
    logic [3:0] cnt_q;
    always_ff @(posedge clock) begin
        can_tx_ok <= 1'b0;
        can_err <= 3'h0;
        rx_valid <= 1'b0;
        rx_id <= resetn ? ~rx_id : 29'h0;
        rx_byte0 <= resetn ? ~rx_byte0 : 8'h00;
        rx_byte1 <= resetn ? ~rx_byte1 : 8'h00;
        cnt_q <= (cnt_q != 4'h0) ? cnt_q + 4'h1 : 4'h0;
        if (can_tx_req) begin
            cnt_q <= 4'h1;
        end
        if (cnt_q == 4'h3) begin
            // wrong rate gives a bit error, nobody listening an ack error
            can_err <= (can_rate != good_rate) ? 3'h2 : {2'b00, ack_missing};
            can_tx_ok <= can_rate == good_rate && !ack_missing;
            if (can_rate != good_rate || ack_missing) begin
                cnt_q <= 4'h0;
            end
        end
        if (cnt_q == 4'h6) begin
            cnt_q <= 4'h0;
            rx_valid <= can_ext_id ? ext_reply : std_reply != 2'h0;
            rx_id <= can_ext_id ? 29'h18DAF11A : 29'h7E9;
            rx_byte0 <= (std_reply == 2'h2 && !can_ext_id) ?
                8'h7F : 8'h41;
            rx_byte1 <= std_reply == 2'h2 && !can_ext_id ? 8'h01 : 8'h00;
        end
        if (!resetn || !can_connect) begin
            cnt_q <= 4'h0;
        end
    end
endmodule : obdscn_bus

/* obdscn_tb_top.sv */
// obdscn_tb_top: directed scenarios for the scan sequencer
// assumes obdscn_bus as the vehicle side, short sender timeout
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin \
    miscompares++; $display("Error %s exp %0h got %0h", nm, exp, got); end end
module obdscn_tb_top;
    localparam int TMO = 200;
    localparam logic [15:0] R0 = 16'h01F4, R1 = 16'h00FA, R2 = 16'h007D;
    logic clock = 1'b0, resetn = 1'b0, start = 1'b0, tce = 1'b1, hdr = 1'b1;
    logic [63:0] list = 64'h0;
    logic [2:0] rate_count = 3'h0, tag_idx = 3'h0;
    logic [15:0] active = 16'h0, good_rate = 16'h0, first_rate, last_rate;
    logic [23:0] window = 24'h000028;
    logic tag_wr = 1'b0, ack_missing = 1'b0, ext_reply = 1'b0;
    logic [7:0] tag_addr = 8'h00, tag_val = 8'h00, src_seen, tag_seen;
    logic [1:0] std_reply = 2'h0, result;
    logic [15:0] can_rate, can_tx_data, detected_rate;
    logic [28:0] can_tx_id, rx_id;
    logic [2:0] can_err;
    logic [7:0] rx_byte0, rx_byte1, resp_src, response_tag;
    logic [63:0] responders;
    logic [7:0] responder_valid;
    logic can_connect, can_tx_req, can_tx_abort, can_ext_id, can_tx_ok;
    logic rx_valid, busy, transmit_done_flag, tx_failed, resp_pos, resp_neg;
    int miscompares = 0, n_checks = 0, n_req = 0, pos_n = 0, neg_n = 0;
    obdscn_top #(.RATES(4), .TIMEOUT_CYC(TMO), .UNITS(8)) obdscn_top_inst (
        .clock(clock), .resetn(resetn), .start(start),
        .candidate_rate_list(list), .rate_count(rate_count),
        .active_bit_rate_setting(active), .transmit_confirm_enable(tce),
        .header_info_enable(hdr), .resp_window(window), .tag_wr(tag_wr),
        .tag_idx(tag_idx), .tag_addr(tag_addr), .tag_val(tag_val),
        .can_rate(can_rate), .can_connect(can_connect),
        .can_tx_req(can_tx_req), .can_tx_abort(can_tx_abort),
        .can_ext_id(can_ext_id), .can_tx_id(can_tx_id),
        .can_tx_data(can_tx_data), .can_tx_ok(can_tx_ok), .can_err(can_err),
        .rx_valid(rx_valid), .rx_id(rx_id), .rx_byte0(rx_byte0),
        .rx_byte1(rx_byte1), .busy(busy),
        .transmit_done_flag(transmit_done_flag),
        .tx_failed(tx_failed), .result(result), .detected_rate(detected_rate),
        .resp_pos(resp_pos), .resp_neg(resp_neg), .resp_src(resp_src),
        .response_tag(response_tag), .responders(responders),
        .responder_valid(responder_valid));
    obdscn_bus obdscn_bus_inst (.clock(clock), .resetn(resetn),
        .good_rate(good_rate), .ack_missing(ack_missing),
        .std_reply(std_reply), .ext_reply(ext_reply), .can_rate(can_rate),
        .can_connect(can_connect), .can_tx_req(can_tx_req),
        .can_ext_id(can_ext_id), .can_tx_ok(can_tx_ok), .can_err(can_err),
        .rx_valid(rx_valid), .rx_id(rx_id), .rx_byte0(rx_byte0),
        .rx_byte1(rx_byte1));
    initial begin
        forever #4 clock = ~clock;
    end
    // records requests and replies as they pass
    always @(posedge clock) begin
        if (can_tx_req) begin
            first_rate = (n_req == 0) ? can_rate : first_rate;
            last_rate = can_rate;
            n_req++;
        end
        if (resp_pos) begin
            pos_n++;
            src_seen = resp_src;
            tag_seen = response_tag;
        end
        if (resp_neg) neg_n++;
    end
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_of_test
    task automatic run_scan(input logic [63:0] l, input logic [2:0] n);
        int i;
        @(posedge clock);
        list <= l;
        rate_count <= n;
        n_req = 0;
        pos_n = 0;
        neg_n = 0;
        @(posedge clock);
        start <= 1'b1;
        @(posedge clock);
        start <= 1'b0;
        i = 0;
        do begin
            @(negedge clock);
            i++;
        end while (busy !== 1'b0 && i < 4000);
        if (i >= 4000) begin
            miscompares++;
            end_of_test();
        end
    endtask : run_scan
    task automatic t_scan;
        good_rate <= R1;
        std_reply <= 2'h1;
        run_scan({16'h0, R2, R1, R0}, 3'h3);
        `CHK("first rate", R0, first_rate);
        `CHK("done flag", 1'b1, transmit_done_flag);
        `CHK("rate", R1, detected_rate);
        `CHK("result", 2'h1, result);
        `CHK("positive", 1'b1, pos_n != 0);
        `CHK("source", 8'h01, src_seen);
        `CHK("tag", 8'hFF, tag_seen);
        `CHK("units", 8'h01, responder_valid);
        `CHK("unit addr", 8'h01, responders[7:0]);
        $display("test scan done");
    endtask : t_scan
    task automatic t_tag;
        @(posedge clock);
        tce <= 1'b0;
        tag_wr <= 1'b1;
        tag_addr <= 8'h01;
        tag_val <= 8'h22;
        @(posedge clock);
        tag_wr <= 1'b0;
        run_scan({48'h0, R1}, 3'h1);
        `CHK("tag set", 8'h22, tag_seen);
        `CHK("confirm off", 1'b0, transmit_done_flag);
        `CHK("rate kept", R1, detected_rate);
        $display("test tag done");
    endtask : t_tag
    task automatic t_neg_ext;
        @(posedge clock);
        tce <= 1'b1;
        good_rate <= R2;
        active <= R2;
        hdr <= 1'b0;
        std_reply <= 2'h2;
        ext_reply <= 1'b1;
        run_scan(64'h0, 3'h0);
        `CHK("active rate", R2, first_rate);
        `CHK("negative", 1'b1, neg_n != 0);
        `CHK("ext result", 2'h2, result);
        `CHK("ext id", 1'b1, can_ext_id);
        `CHK("no header", 8'h00, src_seen);
        `CHK("ext unit", 8'h1A, responders[7:0]);
        $display("test neg ext done");
    endtask : t_neg_ext
    task automatic t_fail;
        @(posedge clock);
        good_rate <= 16'h0;
        hdr <= 1'b1;
        run_scan({32'h0, R1, R0}, 3'h2);
        `CHK("tries", 2, n_req);
        `CHK("last rate", R1, last_rate);
        `CHK("failed", 1'b1, tx_failed);
        `CHK("fail result", 2'h3, result);
        `CHK("no done", 1'b0, transmit_done_flag);
        `CHK("no rate", 16'h0000, detected_rate);
        $display("test fail done");
    endtask : t_fail
    task automatic t_ack;
        good_rate <= R0;
        ack_missing <= 1'b1;
        run_scan({48'h0, R0}, 3'h1);
        `CHK("retried", 1'b1, n_req > 1);
        `CHK("one rate", R0, last_rate);
        `CHK("ack fail", 1'b1, tx_failed);
        $display("test ack done");
    endtask : t_ack
    initial begin
        repeat (10) @(posedge clock);
        resetn <= 1'b1;
        t_scan();
        t_tag();
        t_neg_ext();
        t_fail();
        t_ack();
        end_of_test();
    end
endmodule : obdscn_tb_top
